// File: shared/nvac_pkg.sv
package nvac_pkg;
    // register word offsets (byte addresses on the wishbone bus)
    localparam logic [4:0] ADDR_LOW_OFS = 5'h00;
    localparam logic [4:0] ADDR_HIGH_OFS = 5'h04;
    localparam logic [4:0] DATA_OFS = 5'h08;
    localparam logic [4:0] UNLOCK_OFS = 5'h0c;
    localparam logic [4:0] CONTROL_OFS = 5'h10;
    localparam logic [4:0] FLAG_OFS = 5'h14;
    localparam logic [4:0] MASK_OFS = 5'h18;
    // control register fields
    localparam int RD_BIT = 0;
    localparam int WR_BIT = 1;
    localparam int WRITE_ENABLE_GATE_BIT = 2;
    localparam int WRITE_ERROR_FLAG_BIT = 3;
    localparam int ERASE_BIT = 4;
    localparam int CFG_BIT = 6;
    localparam int MEM_BIT = 7;
    // flag register field
    localparam int DONE_BIT = 4;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [1:0] ADDR_HIGH_MASK = 2'h3;
    // self-timed programming time
    localparam int WRITE_TIME_US = 4;
    localparam int CLK_MHZ = 250;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
endpackage

// File: rtl/nvac_top.sv
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
// Contract
// - read data lands next cycle
// - data holds until next read or write
// - write needs 55h, AAh, then write start
// - write start refused without write enable
// - one write cannot set enable and start
// - hardware never clears write enable
// - address, data and control registers frozen while write in progress
// - completion clears start, sets done flag
// - done flag sticks until software clears
// - start bits set by one, hardware clears
// - error leaves space select bits intact
// - erase bit chooses erase-then-write or write
module nvac_top #(
    parameter int DEPTH_BITS = 8,
    parameter bit HAS_HIGH = 1'b0,
    parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
    input wire logic core_clk, // 250 MHz clock
    input wire logic rst_n, // synchronous reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [4:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic irq // level interrupt
);
    localparam int AW = 10;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    typedef enum logic [1:0] {IDLE, KEY1, ARMED} nvac_key_t;
    typedef enum logic [1:0] {READY, ERASING, WRITING} nvac_prog_t;

    typedef struct packed {
        logic [7:0] addrLow;
        logic [1:0] addrHigh;
        logic [7:0] data;
        logic memSel;
        logic cfgSel;
        logic erase;
        logic write_error_flag;
        logic write_enable_gate;
        logic wrStart;
        logic rdStart;
        logic [7:0] flags;
        logic [7:0] mask;
        nvac_key_t key;
        nvac_prog_t prog;
        logic [CW-1:0] timer;
        logic ack;
        logic [31:0] rdata;
    } nvac_state_t;

    nvac_state_t st, next_st;
    logic [7:0] mem [0:(1<<DEPTH_BITS)-1];
    logic [DEPTH_BITS-1:0] memAddr;
    logic memWe;
    logic [7:0] memWdata;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    // upper bits only on variants with the high register
    function automatic logic [DEPTH_BITS-1:0] formAddr(input logic [7:0] lo, input logic [1:0] hi);
        logic [AW-1:0] full;
        full = HAS_HIGH ? {hi, lo} : {2'h0, lo};
        formAddr = full[DEPTH_BITS-1:0];
    endfunction

    logic req;
    logic wrAcc;
    logic busy;
    logic [7:0] wbyte;
    logic [7:0] ctrlRead;

    assign req = wb_cyc_i && wb_stb_i && !st.ack;
    assign wrAcc = req && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign busy = st.prog != READY;
    assign memAddr = formAddr(st.addrLow, st.addrHigh);
    assign ctrlRead = {st.memSel, st.cfgSel, 1'b0, st.erase, st.write_error_flag, st.write_enable_gate, st.wrStart, st.rdStart};

    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.rdStart = 1'b0;
        memWe = 1'b0;
        memWdata = st.data;
        // read completes in one cycle into the data register
        if (st.rdStart) begin
            next_st.data = mem[memAddr];
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                nvac_pkg::ADDR_LOW_OFS: next_st.rdata = {24'h0, st.addrLow};
                nvac_pkg::ADDR_HIGH_OFS: next_st.rdata = {30'h0, st.addrHigh & nvac_pkg::ADDR_HIGH_MASK};
                nvac_pkg::DATA_OFS: next_st.rdata = {24'h0, st.data};
                nvac_pkg::CONTROL_OFS: next_st.rdata = {24'h0, ctrlRead};
                nvac_pkg::FLAG_OFS: next_st.rdata = {24'h0, st.flags};
                nvac_pkg::MASK_OFS: next_st.rdata = {24'h0, st.mask};
                default: next_st.rdata = 32'h0;
            endcase
        end
        if (wrAcc) begin
            // unlock sequence tracker; any other unlock write breaks it
            if (hit(wb_adr_i, nvac_pkg::UNLOCK_OFS)) begin
                if (wbyte == nvac_pkg::KEY_FIRST)
                    next_st.key = KEY1;
                else if (wbyte == nvac_pkg::KEY_SECOND && st.key == KEY1)
                    next_st.key = ARMED;
                else
                    next_st.key = IDLE;
            end
            // frozen while programming
            if (!busy) begin
                if (hit(wb_adr_i, nvac_pkg::ADDR_LOW_OFS))
                    next_st.addrLow = wbyte;
                if (hit(wb_adr_i, nvac_pkg::ADDR_HIGH_OFS) && HAS_HIGH)
                    next_st.addrHigh = wbyte[1:0];
                if (hit(wb_adr_i, nvac_pkg::DATA_OFS))
                    next_st.data = wbyte;
                if (hit(wb_adr_i, nvac_pkg::CONTROL_OFS)) begin
                    next_st.memSel = wbyte[nvac_pkg::MEM_BIT];
                    next_st.cfgSel = wbyte[nvac_pkg::CFG_BIT];
                    next_st.erase = wbyte[nvac_pkg::ERASE_BIT];
                    next_st.write_error_flag = wbyte[nvac_pkg::WRITE_ERROR_FLAG_BIT];
                    next_st.write_enable_gate = wbyte[nvac_pkg::WRITE_ENABLE_GATE_BIT];
                    // reads only from data space
                    if (wbyte[nvac_pkg::RD_BIT] && !wbyte[nvac_pkg::MEM_BIT] && !wbyte[nvac_pkg::CFG_BIT])
                        next_st.rdStart = 1'b1;
                    // gate must already be set; same-write enable does not count
                    if (wbyte[nvac_pkg::WR_BIT]) begin
                        if (st.write_enable_gate && st.key == ARMED) begin
                            next_st.wrStart = 1'b1;
                            next_st.prog = st.erase ? ERASING : WRITING;
                            next_st.timer = CW'(WRITE_CYCLES);
                        end else if (st.key != ARMED || !st.write_enable_gate) begin
                            next_st.write_error_flag = 1'b1;
                        end
                    end
                    next_st.key = IDLE;
                end
            end
            if (hit(wb_adr_i, nvac_pkg::FLAG_OFS))
                next_st.flags = st.flags & ~wbyte;
            if (hit(wb_adr_i, nvac_pkg::MASK_OFS))
                next_st.mask = wbyte;
        end
        // self-timed erase/write; erase phase then program phase
        unique case (st.prog)
            READY: ;
            ERASING: begin
                if (st.timer == CW'(1)) begin
                    memWe = 1'b1;
                    memWdata = 8'hff;
                    next_st.prog = WRITING;
                    next_st.timer = CW'(WRITE_CYCLES);
                end else begin
                    next_st.timer = st.timer - CW'(1);
                end
            end
            WRITING: begin
                if (st.timer == CW'(1)) begin
                    memWe = 1'b1;
                    next_st.prog = READY;
                    next_st.wrStart = 1'b0;
                end else begin
                    next_st.timer = st.timer - CW'(1);
                end
            end
        endcase
        // set beats software clear
        if (st.prog == WRITING && st.timer == CW'(1))
            next_st.flags[nvac_pkg::DONE_BIT] = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.flags <= nvac_pkg::FLAG_RESET;
            st.mask <= nvac_pkg::MASK_RESET;
            st.key <= IDLE;
            st.prog <= READY;
        end else begin
            st <= next_st;
        end
        if (memWe)
            mem[memAddr] <= memWdata;
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign irq = |(st.flags & st.mask);
endmodule // nvac_top

// File: test/nvac_assertions.sv
`timescale 1ns/10ps
module nvac_assertions (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [4:0] wb_adr_i, // address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic irq // interrupt
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic rdAck;
    logic ctl;
    logic wenSeen;
    assign rdAck = wb_ack_o && !wb_we_i;
    assign ctl = wb_adr_i == nvac_pkg::CONTROL_OFS;
    // only software control writes may take the gate away
    always_ff @(posedge core_clk) begin
        if (!rst_n || (wb_ack_o && wb_we_i && ctl)) begin
            wenSeen <= 1'b0;
        end else if (rdAck && ctl) begin
            wenSeen <= wb_dat_o[nvac_pkg::WRITE_ENABLE_GATE_BIT];
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    upper_zero_a: assert property (rdAck |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    dark_read_a: assert property (rdAck && (wb_adr_i == nvac_pkg::UNLOCK_OFS || wb_adr_i == 5'h1c)
        |-> wb_dat_o == 32'h0) else $error("key or hole reads nonzero");
    data_hold_a: assert property ($changed(wb_dat_o) |-> rdAck) else $error("read data moved");
    write_enable_gate_keep_a: assert property (rdAck && ctl && wenSeen |-> wb_dat_o[nvac_pkg::WRITE_ENABLE_GATE_BIT])
        else $error("gate cleared");
    irq_mask_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == nvac_pkg::MASK_OFS && wb_dat_i[7:0] == 8'h00
        |-> ##2 !irq) else $error("masked irq high");
    cover property (rdAck && wb_adr_i == nvac_pkg::DATA_OFS);
    cover property ($rose(irq));
    cover property (wb_ack_o && wb_we_i && wb_adr_i == nvac_pkg::UNLOCK_OFS);
endmodule // nvac_assertions
bind nvac_top nvac_assertions i_chk (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int WC = 40;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic [7:0] v;
    int err_total = 0;
    int n_tests = 0;
    int ticks = 0;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, g); \
err_total++; end end
    nvac_top #(.WRITE_CYCLES(WC)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        ticks++;
        if (ticks == 6000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        v = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK($sformatf("reg %h", a), e, v)
    endtask
    task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        wr(nvac_pkg::MASK_OFS, 8'h00);
        wr(nvac_pkg::ADDR_LOW_OFS, a);
        wr(nvac_pkg::DATA_OFS, d);
        wr(nvac_pkg::CONTROL_OFS, c);
        wr(nvac_pkg::UNLOCK_OFS, nvac_pkg::KEY_FIRST);
        wr(nvac_pkg::UNLOCK_OFS, nvac_pkg::KEY_SECOND);
        wr(nvac_pkg::CONTROL_OFS, c | 8'h02);
    endtask
    task automatic wait_done();
        v = 8'h00;
        for (int k = 0; k < 200 && v[4] !== 1'b1; k++) bus(1'b0, nvac_pkg::FLAG_OFS, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(nvac_pkg::CONTROL_OFS, nvac_pkg::CONTROL_RESET);
        rdc(nvac_pkg::FLAG_OFS, nvac_pkg::FLAG_RESET);
        rdc(nvac_pkg::MASK_OFS, nvac_pkg::MASK_RESET);
        wr(5'h1c, 8'h5a);
        rdc(5'h1c, 8'h00);
        rdc(nvac_pkg::UNLOCK_OFS, 8'h00);
        wr(nvac_pkg::CONTROL_OFS, 8'hc6);
        rdc(nvac_pkg::CONTROL_OFS, 8'hcc);
        wr(nvac_pkg::CONTROL_OFS, 8'h04);
        wr(nvac_pkg::CONTROL_OFS, 8'h06);
        rdc(nvac_pkg::CONTROL_OFS, 8'h0c);
        prog(8'h05, 8'h3c, 8'h04);
        wr(nvac_pkg::DATA_OFS, 8'h99);
        wr(nvac_pkg::CONTROL_OFS, 8'h00);
        rdc(nvac_pkg::CONTROL_OFS, 8'h06);
        rdc(nvac_pkg::DATA_OFS, 8'h3c);
        wait_done();
        rdc(nvac_pkg::CONTROL_OFS, 8'h04);
        rdc(nvac_pkg::FLAG_OFS, 8'h10);
        `CHK("irq", 1'b0, irq)
        wr(nvac_pkg::MASK_OFS, 8'h10);
        repeat (2) @(posedge core_clk);
        `CHK("irq", 1'b1, irq)
        wr(nvac_pkg::FLAG_OFS, 8'h10);
        repeat (2) @(posedge core_clk);
        `CHK("irq", 1'b0, irq)
        wr(nvac_pkg::ADDR_HIGH_OFS, 8'h03);
        wr(nvac_pkg::DATA_OFS, 8'h00);
        wr(nvac_pkg::CONTROL_OFS, 8'h05);
        rdc(nvac_pkg::DATA_OFS, 8'h3c);
        rdc(nvac_pkg::CONTROL_OFS, 8'h04);
        prog(8'h07, 8'h81, 8'h14);
        // past a plain write time, so only an erase cycle is still busy
        repeat (WC) @(posedge core_clk);
        rdc(nvac_pkg::CONTROL_OFS, 8'h16);
        wait_done();
        wr(nvac_pkg::FLAG_OFS, 8'h10);
        wr(nvac_pkg::CONTROL_OFS, 8'h01);
        rdc(nvac_pkg::DATA_OFS, 8'h81);
        wr(nvac_pkg::MASK_OFS, 8'h00);
        print_verdict();
    end
endmodule // tb
